/* logic/trc_pkg.sv */
// package for the threshold relay control block
package trc_pkg;
    localparam int VAL_W = 16;
    localparam int DLY_W = 10;
    localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E7;
    localparam int CLK_HZ = 10_000_000;
    localparam int TENTH_S_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TENTH_S_MS;
    localparam int MIN_MULT = 60;

    typedef enum logic [2:0] {
        MODE_DISABLED, MODE_ON_ABOVE, MODE_OFF_ABOVE,
        MODE_INSIDE, MODE_OUTSIDE, MODE_REMOTE
    } trc_mode_t;

    typedef enum logic [1:0] {
        ACT_KEEP, ACT_ON, ACT_OFF
    } trc_action_t;

    typedef struct packed {
        trc_mode_t mode;
        trc_action_t critical_action;
        logic signed [VAL_W-1:0] first_threshold;
        logic signed [VAL_W-1:0] second_threshold;
        logic [VAL_W-1:0] hysteresis_half_width;
        logic [DLY_W-1:0] turn_on_delay;
        logic [DLY_W-1:0] turn_off_delay;
        logic unit_minutes;
        logic use_peak;
        logic relay_fitted;
    } trc_cfg_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] live_value;
        logic signed [VAL_W-1:0] peak_value;
        logic peak_active;
        logic out_of_range;
        logic comm_timeout;
        logic remote_relay;
    } trc_meas_t;
endpackage

/* logic/trc_relay_ctrl.sv */
// relay and indicator control from thresholds with hysteresis and delays
`timescale 1ns/10ps
`default_nettype none
module trc_relay_ctrl #(
    parameter int TICK_CYCLES = trc_pkg::TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire trc_pkg::trc_cfg_t cfg_i,
    input wire trc_pkg::trc_meas_t meas_i,
    output logic relay_o,
    output logic led_o,
    output logic pending_o
);
    import trc_pkg::*;

    // a prescaler of zero cycles cannot make the 0.1 s tick
    if (TICK_CYCLES < 1) begin : g_tick_check
        $error("TICK_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [31:0] pre;
        logic [5:0] mins;
        logic [DLY_W-1:0] cnt;
        logic target_on;
        logic pend;
        logic state;
        logic relay;
        logic led;
    } trc_state_t;

    trc_state_t s_q;
    trc_state_t s_d;

    logic signed [VAL_W+1:0] val;
    logic signed [VAL_W+1:0] lo_t;
    logic signed [VAL_W+1:0] hi_t;
    logic signed [VAL_W+1:0] hy;
    logic above_lo;
    logic below_lo;
    logic above_hi;
    logic below_hi;
    logic want_on;
    logic want_off;
    logic tick;
    logic [DLY_W-1:0] need;
    logic done;
    logic thr_mode;
    logic crit;
    logic zero_dly;

    always_comb begin
        // use the held peak only while peak detection is active
        if (cfg_i.use_peak && meas_i.peak_active) begin
            val = (VAL_W+2)'(meas_i.peak_value);
        end else begin
            val = (VAL_W+2)'(meas_i.live_value);
        end
        hy = (VAL_W+2)'({1'b0, cfg_i.hysteresis_half_width});
        if (cfg_i.first_threshold <= cfg_i.second_threshold) begin
            lo_t = (VAL_W+2)'(cfg_i.first_threshold);
            hi_t = (VAL_W+2)'(cfg_i.second_threshold);
        end else begin
            lo_t = (VAL_W+2)'(cfg_i.second_threshold);
            hi_t = (VAL_W+2)'(cfg_i.first_threshold);
        end
        if (cfg_i.mode == MODE_ON_ABOVE || cfg_i.mode == MODE_OFF_ABOVE) begin
            lo_t = (VAL_W+2)'(cfg_i.first_threshold);
            hi_t = lo_t;
        end
        // strict border crossing; inside the band nothing is wanted
        above_lo = val > lo_t + hy;
        below_lo = val < lo_t - hy;
        above_hi = val > hi_t + hy;
        below_hi = val < hi_t - hy;
        want_on = 1'b0;
        want_off = 1'b0;
        case (cfg_i.mode)
            MODE_ON_ABOVE: begin
                want_on = above_lo;
                want_off = below_lo;
            end
            MODE_OFF_ABOVE: begin
                want_on = below_lo;
                want_off = above_lo;
            end
            MODE_INSIDE: begin
                want_on = above_lo && below_hi;
                want_off = below_lo || above_hi;
            end
            MODE_OUTSIDE: begin
                want_on = below_lo || above_hi;
                want_off = above_lo && below_hi;
            end
            default: begin
                want_on = 1'b0;
                want_off = 1'b0;
            end
        endcase
    end

    always_comb begin
        // 0.1 s tick, stretched by 60 in minute mode
        tick = (s_q.pre == 32'(TICK_CYCLES - 1)) &&
            (!cfg_i.unit_minutes || s_q.mins == 6'(MIN_MULT - 1));
        // settings above 99.9 saturate to 99.9
        need = s_q.target_on ? cfg_i.turn_on_delay : cfg_i.turn_off_delay;
        if (need > DLY_MAX) begin
            need = DLY_MAX;
        end
        done = tick && (s_q.cnt + DLY_W'(1) >= need);
        thr_mode = cfg_i.mode inside {MODE_ON_ABOVE, MODE_OFF_ABOVE,
            MODE_INSIDE, MODE_OUTSIDE};
        // critical source depends on the mode
        crit = (cfg_i.mode == MODE_REMOTE) ? meas_i.comm_timeout
                                           : meas_i.out_of_range;
        zero_dly = (want_on ? cfg_i.turn_on_delay
                            : cfg_i.turn_off_delay) == '0;
    end

    always_comb begin
        s_d = s_q;
        s_d.pre = (s_q.pre == 32'(TICK_CYCLES - 1)) ? 32'h0 : s_q.pre + 32'h1;
        if (s_q.pre == 32'(TICK_CYCLES - 1)) begin
            s_d.mins = (s_q.mins == 6'(MIN_MULT - 1)) ? 6'h0 : s_q.mins + 6'h1;
        end
        if ((want_on && !s_q.state) || (want_off && s_q.state)) begin
            if (zero_dly) begin
                // a delay set to zero mid-qualification switches at once
                s_d.state = want_on;
                s_d.pend = 1'b0;
                s_d.cnt = '0;
            end else if (!s_q.pend || s_q.target_on != want_on) begin
                // new qualification starts from zero
                s_d.pend = 1'b1;
                s_d.target_on = want_on;
                s_d.cnt = '0;
                s_d.pre = 32'h0;
                s_d.mins = 6'h0;
            end else if (done) begin
                s_d.state = s_q.target_on;
                s_d.pend = 1'b0;
            end else if (tick) begin
                s_d.cnt = s_q.cnt + DLY_W'(1);
            end
        end else begin
            // back across the border or within band: drop timer, keep state
            s_d.pend = 1'b0;
            s_d.cnt = '0;
        end
        if (cfg_i.mode == MODE_DISABLED) begin
            s_d.state = 1'b0;
            s_d.pend = 1'b0;
        end else if (cfg_i.mode == MODE_REMOTE) begin
            s_d.state = meas_i.remote_relay;
            s_d.pend = 1'b0;
        end
        if (crit) begin
            if (cfg_i.mode != MODE_DISABLED) begin
                case (cfg_i.critical_action)
                    ACT_ON: s_d.state = 1'b1;
                    ACT_OFF: s_d.state = 1'b0;
                    default: s_d.state = s_d.state;
                endcase
                s_d.pend = (cfg_i.critical_action == ACT_KEEP) && s_d.pend;
            end
        end
        // logic runs without a fitted relay; indicator still shows state
        s_d.relay = cfg_i.relay_fitted && s_d.state;
        s_d.led = s_d.state;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign relay_o = s_q.relay;
    assign led_o = s_q.led;
    assign pending_o = s_q.pend;

    // relay output lags the fitted setting by one registered cycle
    a_led_mirror: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(cfg_i.relay_fitted) |-> led_o == relay_o)
        else $error("indicator differs from relay");
    a_unfitted_off: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !$past(cfg_i.relay_fitted) |-> !relay_o)
        else $error("unfitted relay driven");
    a_relay_implies_led: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        relay_o |-> led_o)
        else $error("relay on with indicator off");
    a_disabled_off: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(cfg_i.mode) == MODE_DISABLED |-> !led_o)
        else $error("disabled mode drove relay");
    a_disabled_idle: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg_i.mode == MODE_DISABLED |=> !pending_o)
        else $error("disabled mode ran a delay");
    a_remote_follow: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_i.mode == MODE_REMOTE && !meas_i.comm_timeout)
        |=> led_o == $past(meas_i.remote_relay))
        else $error("remote state not followed");
    a_remote_idle: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg_i.mode == MODE_REMOTE |=> !pending_o)
        else $error("remote mode ran a delay");
    a_crit_on: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_i.mode != MODE_DISABLED && cfg_i.critical_action == ACT_ON &&
         crit) |=> led_o)
        else $error("critical force on missed");
    a_crit_off: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_i.mode != MODE_DISABLED && cfg_i.critical_action == ACT_OFF &&
         crit) |=> !led_o)
        else $error("critical force off missed");
    a_crit_keep: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && crit && cfg_i.critical_action == ACT_KEEP &&
         !want_on && !want_off) |=> led_o == $past(led_o))
        else $error("critical keep changed state");
    a_band_hold: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && !want_on && !want_off)
        |=> led_o == $past(led_o))
        else $error("state changed inside band");
    a_zero_delay: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && want_on && !led_o &&
         cfg_i.turn_on_delay == '0) |=> led_o)
        else $error("zero delay switch late");
    a_off_zero_delay: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && want_off && led_o &&
         cfg_i.turn_off_delay == '0) |=> !led_o)
        else $error("zero delay release late");
    a_no_early_on: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && !want_on && !led_o) |=> !led_o)
        else $error("relay on without border crossing");
    a_no_early_off: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && !want_off && led_o) |=> led_o)
        else $error("relay off without border crossing");
    a_delay_starts: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && want_on && !led_o && !pending_o &&
         cfg_i.turn_on_delay != '0) |=> pending_o && !led_o)
        else $error("turn-on delay not started");
    a_off_delay_starts: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && want_off && led_o && !pending_o &&
         cfg_i.turn_off_delay != '0) |=> pending_o && led_o)
        else $error("turn-off delay not started");
    // without a tick no qualification can complete
    a_short_visit: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (thr_mode && !crit && pending_o && !tick &&
         cfg_i.turn_on_delay != '0 && cfg_i.turn_off_delay != '0)
        |=> led_o == $past(led_o))
        else $error("state changed before delay ended");
    a_restart: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (!want_on && !want_off && !crit) |=> !pending_o)
        else $error("timer kept after return");
endmodule
`default_nettype wire

/* tb/trc_meas_src.sv */
// measurement source model feeding the relay control block
`timescale 1ns/10ps
`default_nettype none
module trc_meas_src (
    input wire logic signed [15:0] live_i,
    input wire logic signed [15:0] peak_i,
    input wire logic [3:0] flags_i,
    output var trc_pkg::trc_meas_t meas_o
);
    import trc_pkg::*;
    // flags: peak_active, out_of_range, comm_timeout, remote_relay
    always_comb begin
        meas_o.live_value = live_i;
        meas_o.peak_value = peak_i;
        meas_o.peak_active = flags_i[3];
        meas_o.out_of_range = flags_i[2];
        meas_o.comm_timeout = flags_i[1];
        meas_o.remote_relay = flags_i[0];
    end
endmodule
`default_nettype wire

/* tb/trc_relay_ctrl_tb_top.sv */
// self-checking bench for the threshold relay control block
`timescale 1ns/10ps
`default_nettype none
module trc_relay_ctrl_tb_top;
    import trc_pkg::*;
    localparam int TK = 4;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    trc_cfg_t cfg = '0;
    trc_meas_t meas;
    logic signed [15:0] live = 16'h0000;
    logic signed [15:0] peak = 16'h0000;
    logic [3:0] flg = 4'h0;
    logic relay;
    logic led;
    logic pend;
    int n_errors = 0;
    int n_tests = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    trc_meas_src trc_meas_src_i (.live_i(live), .peak_i(peak),
        .flags_i(flg), .meas_o(meas));
    trc_relay_ctrl #(.TICK_CYCLES(TK)) trc_relay_ctrl_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_i(cfg),
        .meas_i(meas), .relay_o(relay), .led_o(led), .pending_o(pend));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // value changes land at a falling edge, away from sampling
    task automatic go(input logic signed [15:0] v, input int n);
        live = v;
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        cfg.first_threshold = 16'h0064;
        cfg.hysteresis_half_width = 16'h000A;
        cfg.relay_fitted = 1'b1;
        cfg.mode = MODE_ON_ABOVE;
        repeat (5) @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk(relay, 16'h0000);
        go(16'h006F, 2); chk(relay, 16'h0001);
        chk(led, 16'h0001);
        go(16'h0069, 4); chk(relay, 16'h0001);
        go(16'h0059, 2); chk(relay, 16'h0000);
        cfg.mode = MODE_OFF_ABOVE;
        go(16'h006F, 2); chk(relay, 16'h0000);
        go(16'h0059, 2); chk(relay, 16'h0001);
        $display("test single done");
        // thresholds given high first: order must not matter
        cfg.first_threshold = 16'h00C8;
        cfg.second_threshold = 16'h0064;
        cfg.mode = MODE_INSIDE;
        go(16'h0096, 2); chk(relay, 16'h0001);
        go(16'h00FA, 2); chk(relay, 16'h0000);
        go(16'h0032, 2); chk(relay, 16'h0000);
        cfg.mode = MODE_OUTSIDE;
        go(16'h00FA, 2); chk(relay, 16'h0001);
        go(16'h0096, 2); chk(relay, 16'h0000);
        go(16'h0032, 2); chk(relay, 16'h0001);
        $display("test dual done");
        cfg.first_threshold = 16'h0064;
        cfg.mode = MODE_ON_ABOVE;
        go(16'h0032, 2); chk(relay, 16'h0000);
        cfg.critical_action = ACT_ON;
        flg = 4'h4;
        go(16'h0032, 2); chk(relay, 16'h0001);
        cfg.critical_action = ACT_OFF;
        go(16'h00FA, 2); chk(relay, 16'h0000);
        cfg.critical_action = ACT_KEEP;
        go(16'h00FA, 2); chk(relay, 16'h0001);
        cfg.mode = MODE_DISABLED;
        cfg.critical_action = ACT_ON;
        go(16'h00FA, 2); chk(relay, 16'h0000);
        cfg.mode = MODE_REMOTE;
        flg = 4'h1;
        go(16'h0032, 2); chk(relay, 16'h0001);
        flg = 4'h0;
        go(16'h0032, 2); chk(relay, 16'h0000);
        flg = 4'h2;
        go(16'h0032, 2); chk(relay, 16'h0001);
        flg = 4'h0;
        cfg.critical_action = ACT_KEEP;
        $display("test critical done");
        cfg.mode = MODE_ON_ABOVE;
        go(16'h0032, 2); chk(relay, 16'h0000);
        cfg.use_peak = 1'b1;
        peak = 16'h00FA;
        flg = 4'h8;
        go(16'h0032, 2); chk(relay, 16'h0001);
        cfg.use_peak = 1'b0;
        flg = 4'h0;
        go(16'h0032, 2); chk(relay, 16'h0000);
        cfg.relay_fitted = 1'b0;
        go(16'h00FA, 2); chk(led, 16'h0001);
        chk(relay, 16'h0000);
        go(16'h0032, 2); chk(led, 16'h0000);
        cfg.relay_fitted = 1'b1;
        $display("test peak done");
        cfg.turn_on_delay = 10'h002;
        cfg.turn_off_delay = 10'h001;
        go(16'h0032, 2);
        go(16'h00FA, 2); chk(pend, 16'h0001);
        chk(relay, 16'h0000);
        // a short dip must restart the count, so 6 cycles are not enough
        go(16'h00FA, 1); go(16'h0032, 1); go(16'h00FA, 6);
        chk(relay, 16'h0000);
        go(16'h0032, 20); chk(relay, 16'h0000);
        go(16'h00FA, 12); chk(relay, 16'h0001);
        go(16'h0032, 2); chk(relay, 16'h0001);
        go(16'h0032, 8); chk(relay, 16'h0000);
        cfg.unit_minutes = 1'b1;
        cfg.turn_on_delay = 10'h001;
        go(16'h00FA, 200); chk(relay, 16'h0000);
        go(16'h00FA, 60); chk(relay, 16'h0001);
        $display("test delay done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
